// ===== dv/test_phase_shed_and_sense_config_regs.sv
// Purpose: Self-checking bench for the phase shed and sense config bank
// Assumes: Zero wait APB slave, DEM_CYCLES shortened to 20 for run time
// Notes:   Each scenario is a task; expectations come from field codes
`timescale 1ns/10ps
module test_phase_shed_and_sense_config_regs
  import shed_cfg_pkg::*;
;
  localparam int DEM_N = 20;
  // ---------------------------------------------------------------------------
  // Design hookup
  // ---------------------------------------------------------------------------
  logic        clk, reset_n, psel, penable, pwrite, phase_add, discontinuous_conduction, pwm_tristate;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic        pready, pslverr, auto_shed_mode, precharge_low, dem_pulldown_on;
  pin_level_t  power_state_pin;
  sense_cfg_t  sense_cfg;
  int          num_errors, compares;

  phase_shed_and_sense_config_regs #(.DEM_CYCLES(DEM_N)) dut_u (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .power_state_pin(power_state_pin), .phase_add(phase_add),
    .discontinuous_conduction(discontinuous_conduction), .pwm_tristate(pwm_tristate),
    .auto_shed_mode(auto_shed_mode), .precharge_low(precharge_low),
    .dem_pulldown_on(dem_pulldown_on), .sense_cfg(sense_cfg));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    pstrb   <= 4'hf;
    @(posedge clk);
    penable <= 1'b1;
    // No wait count is assumed; a slave that never answers is left to the watchdog
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, idx, wd, rd, err);
  endtask

  task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, idx, 32'h0000_0000, rd, err);
    check(rd, exp);
    check({31'h0, err}, 32'h0000_0000);
  endtask

  // Edges until the chosen output is seen high after the edge
  task automatic count_rise(input int sel, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (((sel == 0) ? auto_shed_mode : dem_pulldown_on) !== 1'b1 && n < 5000);
  endtask
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic test_reset_values;
    logic [31:0] rd;
    logic        err;
    rd_chk(IDX_SHED, 32'h0000_0013);
    rd_chk(IDX_SCRATCH, 32'h0000_0000);
    rd_chk(IDX_FILTER, 32'h0000_002a);
    rd_chk(IDX_OCP, 32'h0000_0000);
    check({23'h0, sense_cfg}, 32'h0000_00a8);
    apb(1'b0, 10'h3ff, 32'h0000_0000, rd, err);
    check({31'h0, err}, 32'h0000_0001);
    $display("test reset_values done");
  endtask

  task automatic test_unlocked_writes;
    wr(IDX_SCRATCH, 32'hffff_ff5a);
    rd_chk(IDX_SCRATCH, 32'h0000_005a);
    check({23'h0, sense_cfg}, 32'h0000_00a8);
    wr(IDX_FILTER, 32'h0000_0055);
    wr(IDX_OCP, 32'h0000_0002);
    rd_chk(IDX_FILTER, 32'h0000_0055);
    check({23'h0, sense_cfg}, {23'h0, 7'h55, 2'b10});
    wr(IDX_OCP, 32'h0000_0001);
    rd_chk(IDX_OCP, 32'h0000_0001);
    check({31'h0, sense_cfg.ocp_digital_flag_en}, 32'h0000_0001);
    check({31'h0, sense_cfg.ocp_analog_en}, 32'h0000_0000);
    $display("test unlocked_writes done");
  endtask

  task automatic test_lock_key;
    wr(IDX_KEY, {24'h0, LOCK_KEY});
    wr(IDX_SHED, 32'h0000_002d);
    wr(IDX_SCRATCH, 32'h0000_00c3);
    wr(IDX_FILTER, 32'h0000_0013);
    wr(IDX_OCP, 32'h0000_0002);
    rd_chk(IDX_SHED, 32'h0000_0013);
    rd_chk(IDX_SCRATCH, 32'h0000_005a);
    rd_chk(IDX_FILTER, 32'h0000_0055);
    rd_chk(IDX_OCP, 32'h0000_0001);
    wr(IDX_KEY, 32'h0000_00a5);
    wr(IDX_OCP, 32'h0000_0003);
    rd_chk(IDX_OCP, 32'h0000_0003);
    $display("test lock_key done");
  endtask

  task automatic test_pin_gate;
    wr(IDX_SHED, 32'h0000_0021);
    rd_chk(IDX_SHED, 32'h0000_0013);
    wr(IDX_OVERRIDE, 32'h0000_0004);
    wr(IDX_SHED, 32'h0000_0021);
    rd_chk(IDX_SHED, 32'h0000_0021);
    wr(IDX_OVERRIDE, 32'h0000_0000);
    $display("test pin_gate done");
  endtask

  task automatic test_deglitch;
    int n;
    @(posedge clk) power_state_pin <= PIN_HIGH;
    wr(IDX_SHED, 32'h0000_000b);
    @(posedge clk) power_state_pin <= PIN_MID;
    repeat (4) @(posedge clk);
    power_state_pin <= PIN_LOW;
    @(posedge clk) power_state_pin <= PIN_MID;
    count_rise(0, n);
    check(32'(n), 32'd11);
    @(posedge clk) phase_add <= 1'b1;
    @(posedge clk) phase_add <= 1'b0;
    #1;
    n = 0;
    while (precharge_low === 1'b1 && n < 100) begin
      n++;
      @(posedge clk);
      #1;
    end
    check(32'(n), 32'd30);
    // Leaving mid first, so the next add meets a block that is not shedding
    @(posedge clk) power_state_pin <= PIN_HIGH;
    @(posedge clk) phase_add <= 1'b1;
    @(posedge clk) phase_add <= 1'b0;
    #1;
    check({31'h0, auto_shed_mode}, 32'h0000_0000);
    repeat (2) @(posedge clk);
    #1;
    check({31'h0, precharge_low}, 32'h0000_0000);
    wr(IDX_SHED, 32'h0000_0003);
    @(posedge clk) power_state_pin <= PIN_MID;
    count_rise(0, n);
    check(32'(n), 32'd1);
    @(posedge clk) power_state_pin <= PIN_HIGH;
    wr(IDX_SHED, 32'h0000_0038);
    @(posedge clk) power_state_pin <= PIN_MID;
    count_rise(0, n);
    check(32'(n), 32'd641);
    $display("test deglitch done");
  endtask

  task automatic test_dem_pulldown;
    int n;
    // Tri-state alone, in continuous conduction, must never bring the pull-down
    @(posedge clk) pwm_tristate <= 1'b1;
    repeat (DEM_N + 5) @(posedge clk);
    #1;
    check({31'h0, dem_pulldown_on}, 32'h0000_0000);
    @(posedge clk) discontinuous_conduction <= 1'b1;
    count_rise(1, n);
    check(32'(n), 32'(DEM_N + 1));
    @(posedge clk) pwm_tristate <= 1'b0;
    @(posedge clk);
    #1;
    check({31'h0, dem_pulldown_on}, 32'h0000_0000);
    $display("test dem_pulldown done");
  endtask
  // ---------------------------------------------------------------------------
  // Sequence and verdict
  // ---------------------------------------------------------------------------
  task automatic results;
    $display("checks %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #200_000;
    num_errors++;
    results();
  end

  initial begin
    num_errors = 0;
    compares   = 0;
    reset_n = 1'b0;
    {psel, penable, pwrite, phase_add, discontinuous_conduction, pwm_tristate} = 6'h00;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    pstrb   = 4'h0;
    power_state_pin = PIN_LOW;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    test_reset_values();
    @(posedge clk) power_state_pin <= PIN_HIGH;
    test_unlocked_writes();
    test_lock_key();
    @(posedge clk) power_state_pin <= PIN_LOW;
    test_pin_gate();
    test_deglitch();
    test_dem_pulldown();
    results();
  end
endmodule // test_phase_shed_and_sense_config_regs

// ===== verilog/phase_shed_and_sense_config_regs.sv
// Purpose: Configuration bank for phase shedding, precharge pulse and sensing
// Assumes: Inputs synchronous to clk; APB master keeps the protocol
// Notes:   Zero wait state slave; unmapped words answer with pslverr
// Operation
// - Enter shedding after mid level outlasts deglitch
// - Deglitch code doubles from 0.1 us
// - Added phase drives low for programmed time
// - Shed register writable: unlocked and pin high/override
// - Scratch register, no effect, unlocked writes only
// - Reference filter delay select, default 25 us
// - Continuous pull-down current select, default 0.2 mA
// - Discontinuous pull-down after 40 us tri-state
// - Filter register writable only when unlocked
// - Analog overcurrent enable bit, reset zero
// - Digital overcurrent flag enable, reset zero
// - Overcurrent register writable only when unlocked
`timescale 1ns/10ps
module phase_shed_and_sense_config_regs
  import shed_cfg_pkg::*;
#(
  parameter int DEM_CYCLES = DEM_TRISTATE_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Power stage status
  input  wire pin_level_t  power_state_pin,
  input  wire logic        phase_add,
  input  wire logic        discontinuous_conduction,
  input  wire logic        pwm_tristate,
  // Control outputs
  output logic             auto_shed_mode,
  output logic             precharge_low,
  output logic             dem_pulldown_on,
  output sense_cfg_t       sense_cfg
);

  // ---------------------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------------------
  logic [7:0]  key;
  logic [7:0]  override_reg;
  logic [5:0]  shed_reg;
  logic [7:0]  scratch;
  logic [6:0]  filter_reg;
  logic [1:0]  ocp_reg;

  logic [9:0]  word_idx;
  logic        aligned;
  logic        wr_access;
  logic        wr_lane;
  logic        unlocked;
  logic        shed_wr_ok;
  logic        mapped;
  logic [31:0] next_prdata;

  assign word_idx   = paddr[11:2];
  assign aligned    = (paddr[1:0] == 2'b00);
  assign wr_access  = psel && penable && pwrite;
  assign wr_lane    = wr_access && pstrb[0] && aligned;
  assign unlocked   = (key != LOCK_KEY);
  assign shed_wr_ok = unlocked && ((power_state_pin == PIN_HIGH) || override_reg[OVERRIDE_BIT]);

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    mapped      = aligned;
    next_prdata = 32'h0000_0000;
    case (word_idx)
      IDX_KEY:      next_prdata[7:0] = key;
      IDX_OVERRIDE: next_prdata[7:0] = override_reg;
      IDX_SHED:     next_prdata[5:0] = shed_reg;
      IDX_SCRATCH:  next_prdata[7:0] = scratch;
      IDX_FILTER:   next_prdata[6:0] = filter_reg;
      IDX_OCP:      next_prdata[1:0] = ocp_reg;
      default:      mapped = 1'b0;
    endcase
    if (!aligned) begin
      next_prdata = 32'h0000_0000;
    end
  end

  // Read data is a flip-flop loaded in the setup cycle, valid in the access cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // The key itself is never locked, otherwise the bank could never reopen
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      key <= KEY_RESET;
    end else if (wr_lane && word_idx == IDX_KEY) begin
      key <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      override_reg <= OVR_RESET;
    end else if (wr_lane && word_idx == IDX_OVERRIDE && unlocked) begin
      override_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shed_reg <= SHED_RESET;
    end else if (wr_lane && word_idx == IDX_SHED && shed_wr_ok) begin
      shed_reg <= pwdata[5:0];
    end
  end

  // Scratch is read back only; nothing in the block looks at it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scratch <= SCR_RESET;
    end else if (wr_lane && word_idx == IDX_SCRATCH && unlocked) begin
      scratch <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      filter_reg <= FILT_RESET;
    end else if (wr_lane && word_idx == IDX_FILTER && unlocked) begin
      filter_reg <= pwdata[6:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ocp_reg <= OCP_RESET;
    end else if (wr_lane && word_idx == IDX_OCP && unlocked) begin
      ocp_reg <= pwdata[1:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Configuration fields to the analog side
  // ---------------------------------------------------------------------------
  assign sense_cfg.filter_sel          = filter_reg[FILTER_LSB +: 2];
  assign sense_cfg.ccm_pulldown_sel    = filter_reg[CCM_PD_LSB +: 3];
  assign sense_cfg.dem_pulldown_sel    = filter_reg[DEM_PD_LSB +: 2];
  assign sense_cfg.ocp_analog_en       = ocp_reg[OCP_ANA_BIT];
  assign sense_cfg.ocp_digital_flag_en = ocp_reg[OCP_DIG_BIT];

  // ---------------------------------------------------------------------------
  // Auto shedding entry deglitch
  // ---------------------------------------------------------------------------
  shed_state_t shed_state;
  logic [9:0]  dg_cnt;
  logic [9:0]  dg_limit;
  logic [2:0]  dg_code;
  logic        pin_mid;

  assign pin_mid = (power_state_pin == PIN_MID);
  assign dg_code = shed_reg[DEGLITCH_LSB +: 3];

  // Code n waits unit times two to the n-1; code 0 means no wait
  always_comb begin
    dg_limit = 10'd0;
    if (dg_code != 3'd0) begin
      dg_limit = 10'(DEGLITCH_UNIT_CYC) << (dg_code - 3'd1);
    end
  end

  // Mid must hold for limit+1 samples, which is strictly longer than limit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shed_state <= SH_IDLE;
      dg_cnt     <= 10'd0;
    end else begin
      case (shed_state)
        SH_IDLE: begin
          dg_cnt <= 10'd1;
          if (pin_mid) begin
            shed_state <= (dg_limit == 10'd0) ? SH_ACTIVE : SH_QUALIFY;
          end
        end
        SH_QUALIFY: begin
          if (!pin_mid) begin
            shed_state <= SH_IDLE;
          end else if (dg_cnt >= dg_limit) begin
            shed_state <= SH_ACTIVE;
          end else begin
            dg_cnt <= dg_cnt + 10'd1;
          end
        end
        SH_ACTIVE: begin
          if (!pin_mid) begin
            shed_state <= SH_IDLE;
          end
        end
        default: shed_state <= SH_IDLE;
      endcase
    end
  end

  assign auto_shed_mode = (shed_state == SH_ACTIVE);

  // ---------------------------------------------------------------------------
  // Precharge low pulse for an added phase
  // ---------------------------------------------------------------------------
  logic [6:0] pre_cnt;
  logic [6:0] pre_limit;

  assign pre_limit = 7'(PRECHG_UNIT_CYC) * 7'(shed_reg[PRECHG_LSB +: 3]);

  // A phase add during a running pulse is ignored; the pulse is not restarted
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      precharge_low <= 1'b0;
      pre_cnt       <= 7'd0;
    end else if (precharge_low) begin
      if (pre_cnt <= 7'd1) begin
        precharge_low <= 1'b0;
      end
      pre_cnt <= pre_cnt - 7'd1;
    end else if (phase_add && auto_shed_mode && pre_limit != 7'd0) begin
      precharge_low <= 1'b1;
      pre_cnt       <= pre_limit;
    end
  end

  // ---------------------------------------------------------------------------
  // Discontinuous sense pull-down qualifier
  // ---------------------------------------------------------------------------
  logic [15:0] tri_cnt;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tri_cnt         <= 16'd0;
      dem_pulldown_on <= 1'b0;
    end else if (!(pwm_tristate && discontinuous_conduction)) begin
      tri_cnt         <= 16'd0;
      dem_pulldown_on <= 1'b0;
    end else begin
      if (tri_cnt <= 16'(DEM_CYCLES)) begin
        tri_cnt <= tri_cnt + 16'd1;
      end
      dem_pulldown_on <= (tri_cnt >= 16'(DEM_CYCLES));
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic [10:0] mid_run;
  logic [7:0]  pre_run;
  logic [7:0]  pre_seen;
  logic [16:0] tri_run;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mid_run  <= 11'd0;
      pre_run  <= 8'd0;
      pre_seen <= 8'd0;
      tri_run  <= 17'd0;
    end else begin
      mid_run  <= !pin_mid ? 11'd0 : (mid_run == 11'h7ff ? mid_run : mid_run + 11'd1);
      pre_run  <= precharge_low ? pre_run + 8'd1 : 8'd0;
      pre_seen <= precharge_low ? pre_seen : {1'b0, pre_limit};
      tri_run  <= !(pwm_tristate && discontinuous_conduction) ? 17'd0 :
                  (tri_run[16] ? tri_run : tri_run + 17'd1);
    end
  end

  sequence s_write_to(logic [9:0] idx);
    psel && penable && pwrite && pstrb[0] && aligned && word_idx == idx;
  endsequence

  sequence s_pulse_start;
    phase_add && auto_shed_mode && !precharge_low && pre_limit != 7'd0;
  endsequence

  sequence s_read_setup(logic [9:0] idx);
    psel && !penable && !pwrite && aligned && word_idx == idx;
  endsequence

  a_shed_needs_mid: assert property (auto_shed_mode |-> $past(pin_mid))
    else $error("auto shed active without mid level");
  a_deglitch_long: assert property ($rose(auto_shed_mode) |-> mid_run >= {1'b0, dg_limit} + 11'd1)
    else $error("auto shed entered before deglitch time");
  a_deglitch_zero: assert property (shed_state == SH_IDLE && pin_mid && dg_code == 3'd0 |=> auto_shed_mode)
    else $error("zero deglitch did not enter at once");
  a_precharge_start: assert property (s_pulse_start |=> precharge_low)
    else $error("precharge pulse did not start");
  a_precharge_len: assert property ($fell(precharge_low) |-> pre_run == pre_seen)
    else $error("precharge pulse length wrong");
  a_dem_late: assert property (dem_pulldown_on |-> tri_run > 17'(DEM_CYCLES))
    else $error("pull-down before tri-state time");
  a_dem_release: assert property (!pwm_tristate |=> !dem_pulldown_on)
    else $error("pull-down held after tri-state ended");
  a_shed_lock: assert property (s_write_to(IDX_SHED) and !shed_wr_ok |=> $stable(shed_reg))
    else $error("locked shed register changed");
  a_scratch_lock: assert property (s_write_to(IDX_SCRATCH) and !unlocked |=> $stable(scratch))
    else $error("locked scratch register changed");
  a_filter_lock: assert property (s_write_to(IDX_FILTER) and !unlocked |=> $stable(filter_reg))
    else $error("locked filter register changed");
  a_ocp_lock: assert property (s_write_to(IDX_OCP) and !unlocked |=> $stable(ocp_reg))
    else $error("locked overcurrent register changed");
  a_blocked_read: assert property ((s_write_to(IDX_SHED) and !shed_wr_ok) ##2 s_read_setup(IDX_SHED)
                                   |=> prdata[5:0] == $past(shed_reg, 3))
    else $error("read after blocked write not stored value");
  a_shed_write: assert property (s_write_to(IDX_SHED) and shed_wr_ok |=> shed_reg == $past(pwdata[5:0]))
    else $error("allowed shed write not taken");
  a_shed_exit: assert property (auto_shed_mode && !pin_mid |=> !auto_shed_mode)
    else $error("auto shed held after mid level ended");
  a_precharge_idle: assert property (phase_add && !auto_shed_mode && !precharge_low |=> !precharge_low)
    else $error("precharge pulse started outside auto shed");
  a_dem_mode_only: assert property (!discontinuous_conduction |=> !dem_pulldown_on)
    else $error("pull-down applied outside discontinuous mode");
  a_scratch_write: assert property (s_write_to(IDX_SCRATCH) and unlocked
                                    |=> scratch == $past(pwdata[7:0]))
    else $error("allowed scratch write not taken");
  a_filter_write: assert property (s_write_to(IDX_FILTER) and unlocked
                                   |=> filter_reg == $past(pwdata[6:0]))
    else $error("allowed filter write not taken");
  a_ocp_write: assert property (s_write_to(IDX_OCP) and unlocked
                                |=> ocp_reg == $past(pwdata[1:0]))
    else $error("allowed overcurrent write not taken");

endmodule  // phase_shed_and_sense_config_regs

// ===== verilog/shed_cfg_pkg.sv
// Purpose: Shared constants and types of the phase shed and sense config bank
// Assumes: 100 MHz clock, APB with 32-bit data, one register per aligned word
// Notes:   Register offsets are word indices; byte address is four times index
package shed_cfg_pkg;
  // ---------------------------------------------------------------------------
  // Register map (word indices)
  // ---------------------------------------------------------------------------
  localparam logic [9:0] IDX_KEY      = 10'h000;
  localparam logic [9:0] IDX_OVERRIDE = 10'h02d;
  localparam logic [9:0] IDX_SHED     = 10'h04a;
  localparam logic [9:0] IDX_SCRATCH  = 10'h04b;
  localparam logic [9:0] IDX_FILTER   = 10'h04c;
  localparam logic [9:0] IDX_OCP      = 10'h04d;
  localparam logic [7:0] LOCK_KEY     = 8'ha6;
  localparam int         OVERRIDE_BIT = 2;
  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int         DEGLITCH_LSB = 3;
  localparam int         PRECHG_LSB   = 0;
  localparam int         FILTER_LSB   = 5;
  localparam int         CCM_PD_LSB   = 2;
  localparam int         DEM_PD_LSB   = 0;
  localparam int         OCP_ANA_BIT  = 1;
  localparam int         OCP_DIG_BIT  = 0;
  localparam logic [5:0] SHED_RESET   = 6'h13;
  localparam logic [7:0] SCR_RESET    = 8'h00;
  localparam logic [6:0] FILT_RESET   = 7'h2a;
  localparam logic [1:0] OCP_RESET    = 2'h0;
  localparam logic [7:0] KEY_RESET    = 8'h00;
  localparam logic [7:0] OVR_RESET    = 8'h00;
  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 10;
  localparam int DEGLITCH_STEP_NS  = 100;
  localparam int PRECHG_STEP_NS    = 100;
  localparam int DEM_TRISTATE_NS   = 40000;
  localparam int DEGLITCH_UNIT_CYC = (DEGLITCH_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRECHG_UNIT_CYC   = (PRECHG_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEM_TRISTATE_CYC  = (DEM_TRISTATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {PIN_LOW = 2'b00, PIN_MID = 2'b01, PIN_HIGH = 2'b10} pin_level_t;
  typedef enum logic [2:0] {SH_IDLE = 3'b001, SH_QUALIFY = 3'b010, SH_ACTIVE = 3'b100} shed_state_t;
  typedef struct packed {
    logic [1:0] filter_sel;
    logic [2:0] ccm_pulldown_sel;
    logic [1:0] dem_pulldown_sel;
    logic       ocp_analog_en;
    logic       ocp_digital_flag_en;
  } sense_cfg_t;
endpackage
